// ==== src/crg_top.sv ====
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "crg_regs.svh"
module crg_top #(
	parameter int WDOG_BASE = 16384,
	parameter int RTI_BASE = 1024,
	parameter int QC_CYCLES = 4096
) (
	// System
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// AXI4-Lite
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// Analog status and events
	input wire logic i_pll_in_tol,
	input wire logic i_pll_track,
	input wire logic i_osc_loss,
	input wire logic i_osc_quality_ok,
	input wire logic i_power_on,
	input wire logic i_low_volt,
	input wire logic i_wait_req,
	input wire logic i_stop_req,
	// Reset pin
	input wire logic i_reset_pin_n,
	output logic o_reset_pin_out,
	output logic o_reset_pin_oe,
	// Clock control
	output logic [7:0] o_loop_multiplier_field,
	output logic [7:0] o_ref_divide_field,
	output logic o_pll_on,
	output logic o_synth_min_freq,
	output logic o_pll_source_select,
	output logic o_bus_div2,
	output logic o_osc_enable,
	output logic o_sys_clk_en,
	output logic o_core_clk_en,
	output logic o_sys_reset,
	output logic o_lock_irq_req
);
	import crg_pkg::*;
	crg_reg_if rif();
	logic pin_n_s;
	logic loss_s;
	logic qual_s;
	crg_axil u_axil (
		.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_awvalid(i_awvalid), .o_awready(o_awready), .i_awaddr(i_awaddr),
		.i_wvalid(i_wvalid), .o_wready(o_wready), .i_wdata(i_wdata), .i_wstrb(i_wstrb),
		.o_bvalid(o_bvalid), .i_bready(i_bready), .o_bresp(o_bresp),
		.i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
		.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_rresp(o_rresp),
		.rif(rif.slave)
	);
	crg_sync #(.INIT(1'b1)) u_sync_pin (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_d(i_reset_pin_n), .o_q(pin_n_s));
	crg_sync u_sync_loss (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_d(i_osc_loss), .o_q(loss_s));
	crg_sync u_sync_qual (.i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst),
		.i_d(i_osc_quality_ok), .o_q(qual_s));

	// ==========================================================
	// State
	typedef struct packed {
		logic [7:0] syn; logic [7:0] refdiv; logic [7:0] flg_w1c; logic [7:0] ien;
		logic [7:0] csel; logic [7:0] pctl; logic [7:0] prate; logic [7:0] wrate;
		logic lock; logic track; logic lock_hold; crg_scm_state_t self_clock_status;
		logic [12:0] qc_cnt; logic [23:0] wd_cnt; logic [23:0] rt_cnt;
		logic armed; logic [5:0] rst_cnt; crg_mode_t mode;
	} crg_st_t;
	crg_st_t st;
	crg_st_t next_st;
	logic scm_on;
	logic wr_syn_ok;
	logic wr_ref_ok;
	logic wd_run;
	logic rt_run;
	logic wd_tmo;
	logic rst_src;
	logic [23:0] wd_lim;
	logic [23:0] rt_lim;
	logic lock_now;
	logic [7:0] flg_rd;

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		scm_on = (st.self_clock_status != CRG_SCM_OFF);
		wr_syn_ok = rif.wr_en && rif.wr_idx == `CRG_IDX_SYN && !st.csel[`CRG_BIT_PLL_SOURCE_SELECT];
		wr_ref_ok = rif.wr_en && rif.wr_idx == `CRG_IDX_REFDIV
			&& !st.csel[`CRG_BIT_PLL_SOURCE_SELECT];
		if (wr_syn_ok) begin
			next_st.syn = rif.wr_data & `CRG_MASK_SYN;
		end
		if (wr_ref_ok) begin
			next_st.refdiv = rif.wr_data & `CRG_MASK_REFDIV;
		end
		if (rif.wr_en && rif.wr_idx == `CRG_IDX_INT) begin
			next_st.ien = rif.wr_data & `CRG_MASK_INT;
		end
		if (rif.wr_en && rif.wr_idx == `CRG_IDX_CSEL) begin
			next_st.csel = rif.wr_data;
		end
		if (rif.wr_en && rif.wr_idx == `CRG_IDX_PCTL) begin
			next_st.pctl = rif.wr_data & `CRG_MASK_PCTL;
		end
		if (rif.wr_en && rif.wr_idx == `CRG_IDX_PRATE) begin
			next_st.prate = rif.wr_data & `CRG_MASK_PRATE;
		end
		if (rif.wr_en && rif.wr_idx == `CRG_IDX_WRATE) begin
			next_st.wrate = rif.wr_data & `CRG_MASK_WRATE;
		end
		if (rif.wr_en && rif.wr_idx == `CRG_IDX_MODE) begin
			next_st.mode = crg_mode_t'(rif.wr_data[1:0]);
		end
		if (i_stop_req) begin
			next_st.mode = CRG_STOP;
		end else if (i_wait_req) begin
			next_st.mode = CRG_WAIT;
		end
		// Lock and track follow the detector, reinit on accepted multiplier or divider write
		lock_now = i_pll_in_tol && !scm_on && st.pctl[`CRG_BIT_PLLON];
		if (wr_syn_ok || wr_ref_ok) begin
			next_st.lock = 1'b0;
			next_st.track = 1'b0;
			next_st.lock_hold = 1'b1;
		end else begin
			next_st.lock_hold = 1'b0;
			next_st.lock = lock_now && !st.lock_hold;
			next_st.track = i_pll_track && !scm_on && !st.lock_hold;
		end
		// Self-clock entry and quality check
		case (st.self_clock_status)
			CRG_SCM_OFF: begin
				if (st.pctl[`CRG_BIT_CME] && st.pctl[`CRG_BIT_SELF_CLOCK_ENABLE] && loss_s) begin
					next_st.self_clock_status = CRG_SCM_ON;
				end
			end
			CRG_SCM_ON: begin
				next_st.qc_cnt = '0;
				next_st.self_clock_status = CRG_SCM_CHECK;
			end
			CRG_SCM_CHECK: begin
				if (!qual_s) begin
					next_st.qc_cnt = '0;
				end else if (st.qc_cnt == 13'(QC_CYCLES - 1)) begin
					next_st.self_clock_status = CRG_SCM_OFF;
				end else begin
					next_st.qc_cnt = st.qc_cnt + 13'h0001;
				end
			end
			default: next_st.self_clock_status = CRG_SCM_OFF;
		endcase
		// Watchdog and periodic timer
		wd_run = (st.mode == CRG_RUN) || (st.mode == CRG_WAIT && !st.csel[`CRG_BIT_COPWAI])
			|| (st.mode == CRG_STOP && st.csel[`CRG_BIT_PSEUDO_STOP_SELECT] && st.pctl[`CRG_BIT_PCE]);
		rt_run = (st.mode == CRG_RUN) || (st.mode == CRG_WAIT && !st.csel[`CRG_BIT_RTIWAI])
			|| (st.mode == CRG_STOP && st.csel[`CRG_BIT_PSEUDO_STOP_SELECT] && st.pctl[`CRG_BIT_PRE]);
		wd_lim = 24'(WDOG_BASE) << st.wrate[2:0];
		rt_lim = 24'(RTI_BASE) << st.prate[6:4];
		wd_tmo = 1'b0;
		if (st.wrate[2:0] != 3'h0 && wd_run && st.rst_cnt == 6'h00) begin
			next_st.wd_cnt = st.wd_cnt + 24'h000001;
			if (st.wd_cnt >= wd_lim) begin
				wd_tmo = 1'b1;
			end
		end
		if (rif.wr_en && rif.wr_idx == `CRG_IDX_ARM) begin
			if (rif.wr_data == `CRG_ARM_KEY1) begin
				next_st.armed = 1'b1;
			end else if (rif.wr_data == `CRG_ARM_KEY2 && st.armed) begin
				next_st.armed = 1'b0;
				next_st.wd_cnt = '0;
			end else begin
				wd_tmo = 1'b1;
			end
		end
		// Sticky flags: write one clears, hardware set wins
		if (rif.wr_en && rif.wr_idx == `CRG_IDX_FLG) begin
			next_st.flg_w1c = next_st.flg_w1c & ~(rif.wr_data & `CRG_FLG_W1C);
		end
		if (st.prate[6:4] != 3'h0 && rt_run) begin
			if (st.rt_cnt >= rt_lim) begin
				next_st.rt_cnt = '0;
				next_st.flg_w1c[`CRG_FLG_RTIF] = 1'b1;
			end else begin
				next_st.rt_cnt = st.rt_cnt + 24'h000001;
			end
		end
		if (st.lock != next_st.lock) begin
			next_st.flg_w1c[`CRG_FLG_LOCKIF] = 1'b1;
		end
		if ((st.self_clock_status == CRG_SCM_OFF) != (next_st.self_clock_status == CRG_SCM_OFF)) begin
			next_st.flg_w1c[`CRG_FLG_SCMIF] = 1'b1;
		end
		if (i_power_on) begin
			next_st.flg_w1c[`CRG_FLG_PORF] = 1'b1;
		end
		if (i_low_volt) begin
			next_st.flg_w1c[`CRG_FLG_LVRF] = 1'b1;
		end
		// System reset stretch
		// Own pin drive is ignored until the released pin has crossed the synchroniser
		rst_src = i_power_on || i_low_volt || wd_tmo
			|| (!pin_n_s && st.rst_cnt <= `CRG_PIN_LISTEN)
			|| (loss_s && st.pctl[`CRG_BIT_CME] && !st.pctl[`CRG_BIT_SELF_CLOCK_ENABLE]);
		if (rst_src) begin
			next_st.rst_cnt = `CRG_RST_STRETCH;
			next_st.wd_cnt = '0;
			next_st.armed = 1'b0;
		end else if (st.rst_cnt != 6'h00) begin
			next_st.rst_cnt = st.rst_cnt - 6'h01;
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st <= '0;
			st.pctl <= `CRG_RST_PCTL;
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Read mux
	always_comb begin
		flg_rd = st.flg_w1c | {4'h0, st.lock, st.track, 1'b0, st.self_clock_status != CRG_SCM_OFF};
		rif.rd_ok = 1'b1;
		rif.wr_ok = (rif.wr_idx <= `CRG_IDX_MODE);
		if (rif.rd_idx == `CRG_IDX_SYN) begin
			rif.rd_data = st.syn;
		end else if (rif.rd_idx == `CRG_IDX_REFDIV) begin
			rif.rd_data = st.refdiv;
		end else if (rif.rd_idx == `CRG_IDX_FLG) begin
			rif.rd_data = flg_rd;
		end else if (rif.rd_idx == `CRG_IDX_INT) begin
			rif.rd_data = st.ien;
		end else if (rif.rd_idx == `CRG_IDX_CSEL) begin
			rif.rd_data = st.csel;
		end else if (rif.rd_idx == `CRG_IDX_PCTL) begin
			rif.rd_data = st.pctl;
		end else if (rif.rd_idx == `CRG_IDX_PRATE) begin
			rif.rd_data = st.prate;
		end else if (rif.rd_idx == `CRG_IDX_WRATE) begin
			rif.rd_data = st.wrate;
		end else if (rif.rd_idx == `CRG_IDX_MODE) begin
			rif.rd_data = {6'h00, st.mode};
		end else if (rif.rd_idx <= `CRG_IDX_ARM) begin
			rif.rd_data = 8'h00;
		end else begin
			rif.rd_data = 8'h00;
			rif.rd_ok = 1'b0;
		end
	end

	// ==========================================================
	// Outputs
	assign o_loop_multiplier_field = st.syn;
	assign o_ref_divide_field = st.refdiv;
	assign o_pll_on = st.pctl[`CRG_BIT_PLLON] || scm_on;
	assign o_synth_min_freq = scm_on;
	assign o_pll_source_select = st.csel[`CRG_BIT_PLL_SOURCE_SELECT] || scm_on;
	assign o_bus_div2 = o_pll_source_select;
	assign o_osc_enable = !(st.mode == CRG_STOP && !st.csel[`CRG_BIT_PSEUDO_STOP_SELECT]);
	assign o_sys_clk_en = (st.mode == CRG_RUN)
		|| (st.mode == CRG_WAIT && !st.csel[`CRG_BIT_SYSWAI]);
	assign o_core_clk_en = (st.mode == CRG_RUN);
	assign o_sys_reset = st.rst_cnt != 6'h00;
	assign o_reset_pin_out = 1'b0;
	assign o_reset_pin_oe = st.rst_cnt > `CRG_PIN_RELEASE;
	assign o_lock_irq_req = st.flg_w1c[`CRG_FLG_LOCKIF] && st.ien[`CRG_FLG_LOCKIF];

	// ==========================================================
	// Checks
	AST_WR_BLOCK: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(rif.wr_en && rif.wr_idx == `CRG_IDX_SYN && st.csel[`CRG_BIT_PLL_SOURCE_SELECT])
		|=> $stable(st.syn)) else $error("multiplier changed while locked out");
	AST_REF_BLOCK: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(rif.wr_en && rif.wr_idx == `CRG_IDX_REFDIV && st.csel[`CRG_BIT_PLL_SOURCE_SELECT])
		|=> $stable(st.refdiv)) else $error("divider changed while locked out");
	AST_LOCK_INIT: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(wr_syn_ok || wr_ref_ok) |=> !st.lock && !st.track ##1 !st.lock)
		else $error("lock not reinitialised");
	AST_TFLG_ZERO: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(rif.rd_en && rif.rd_idx == `CRG_IDX_TFLG) |=> o_rdata == 32'h00000000)
		else $error("test flags not zero");
	AST_SCM_ENTRY: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		$rose(scm_on) |-> $past(st.pctl[`CRG_BIT_CME] && st.pctl[`CRG_BIT_SELF_CLOCK_ENABLE] && loss_s))
		else $error("self-clock without cause");
	AST_SCM_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		$fell(scm_on) |-> $past(qual_s)) else $error("self-clock left without quality");
	AST_STOP_OSC: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(st.mode == CRG_STOP && !st.csel[`CRG_BIT_PSEUDO_STOP_SELECT]) |-> !o_osc_enable && !o_sys_clk_en)
		else $error("full stop left clocks running");
	AST_PIN_RST: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		!pin_n_s |=> o_sys_reset) else $error("pin reset not seen");
	AST_PIN_DRIVE: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		$rose(o_sys_reset) |-> o_reset_pin_oe && !o_reset_pin_out)
		else $error("pin not driven on system reset");
	AST_LOCK_IRQ: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		(st.lock != $past(st.lock)) |-> st.flg_w1c[`CRG_FLG_LOCKIF])
		else $error("lock change not flagged");
	AST_LOCK_SCM: assert property (@(posedge i_clk_sys) disable iff (i_sys_rst)
		scm_on |=> !st.lock) else $error("lock set in self-clock");
endmodule // crg_top

// ==== src/crg_regs.svh ====
// Contract
// - Synth clock equals two times osc clock times (multiplier+1) over (divider+1).
// - Reference divider divides osc clock frequency by its field plus one.
// - Synth clock never falls below the self-clock minimum frequency.
// - With synth clock selected, bus clock is synth clock divided by two.
// - Multiplier writes ignored while the synth source select bit is one.
// - Divider writes ignored while the synth source select bit is one.
// - Accepted multiplier or divider write reinitialises lock and track status.
// - Test flag register reads zero and ignores writes.
// - Self-clock entered only with both enables set and a loss of clock.
// - Self-clock mode holds until the clock quality check passes.
// - Full stop halts oscillator, all clocks, watchdog and periodic timer.
// - Pseudo stop keeps oscillator; watchdog and timer run only if enabled.
// - Wait mode gates system and core clocks per wait-disable bits; here the core clock always stops in wait, only SYSWAI gates the system clock.
// - Reset pin resets chip when low and is driven low on system reset.
// - System reset on power-on, low voltage, watchdog, clock loss, pin.
// - Lock detector requests an interrupt on entering and leaving lock.
// - Registers sit at base plus offset, multiplier 0x0 to watchdog arm 0xb.
// - Lock status follows tolerance, is cleared in self-clock, ignores writes.
`ifndef CRG_REGS_SVH
`define CRG_REGS_SVH
`define CRG_IDX_SYN 4'h0
`define CRG_IDX_REFDIV 4'h1
`define CRG_IDX_TFLG 4'h2
`define CRG_IDX_FLG 4'h3
`define CRG_IDX_INT 4'h4
`define CRG_IDX_CSEL 4'h5
`define CRG_IDX_PCTL 4'h6
`define CRG_IDX_PRATE 4'h7
`define CRG_IDX_WRATE 4'h8
`define CRG_IDX_FBYP 4'h9
`define CRG_IDX_TCTL 4'ha
`define CRG_IDX_ARM 4'hb
`define CRG_IDX_MODE 4'hc
`define CRG_IDX_NONE 4'hf
`define CRG_PIN_RELEASE 6'h03
`define CRG_PIN_LISTEN 6'h01
`define CRG_MASK_SYN 8'h3f
`define CRG_MASK_REFDIV 8'h0f
`define CRG_MASK_INT 8'h92
`define CRG_MASK_PCTL 8'hf7
`define CRG_MASK_PRATE 8'h7f
`define CRG_MASK_WRATE 8'hc7
`define CRG_RST_PCTL 8'hf1
`define CRG_BIT_PLL_SOURCE_SELECT 7
`define CRG_BIT_PSEUDO_STOP_SELECT 6
`define CRG_BIT_SYSWAI 5
`define CRG_BIT_RTIWAI 1
`define CRG_BIT_COPWAI 0
`define CRG_BIT_CME 7
`define CRG_BIT_PLLON 6
`define CRG_BIT_SELF_CLOCK_ENABLE 0
`define CRG_BIT_PRE 2
`define CRG_BIT_PCE 1
`define CRG_FLG_RTIF 7
`define CRG_FLG_PORF 6
`define CRG_FLG_LVRF 5
`define CRG_FLG_LOCKIF 4
`define CRG_FLG_SCMIF 1
`define CRG_FLG_W1C 8'hf2
`define CRG_ARM_KEY1 8'h55
`define CRG_ARM_KEY2 8'haa
`define CRG_RST_STRETCH 6'h3f
`define CRG_RESP_OKAY 2'b00
`define CRG_RESP_SLVERR 2'b10
`endif

// ==== src/crg_pkg.sv ====
package crg_pkg;
	typedef enum logic [1:0] {CRG_RUN, CRG_WAIT, CRG_STOP} crg_mode_t;
	typedef enum logic [1:0] {CRG_SCM_OFF, CRG_SCM_ON, CRG_SCM_CHECK} crg_scm_state_t;
endpackage

// ==== src/crg_reg_if.sv ====
`timescale 1ns/1ps
interface crg_reg_if;
	logic wr_en;
	logic rd_en;
	logic [3:0] wr_idx;
	logic [3:0] rd_idx;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	logic rd_ok;
	logic wr_ok;
	modport slave(output wr_en, rd_en, wr_idx, rd_idx, wr_data, input rd_data, rd_ok, wr_ok);
	modport core(input wr_en, rd_en, wr_idx, rd_idx, wr_data, output rd_data, rd_ok, wr_ok);
endinterface

// ==== src/crg_sync.sv ====
`timescale 1ns/1ps
module crg_sync #(
	parameter logic INIT = 1'b0
) (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_d,
	output logic o_q
);
	import crg_pkg::*;
	typedef struct packed {logic s1; logic s2;} crg_sync_st_t;
	crg_sync_st_t st;
	crg_sync_st_t next_st;
	always_comb begin
		next_st.s1 = i_d;
		next_st.s2 = st.s1;
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st <= {INIT, INIT};
		end else begin
			st <= next_st;
		end
	end
	assign o_q = st.s2;
endmodule // crg_sync

// ==== src/crg_axil.sv ====
`timescale 1ns/1ps
`include "crg_regs.svh"
module crg_axil (
	// System
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// AXI4-Lite
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [7:0] i_awaddr,
	input wire logic i_wvalid,
	output logic o_wready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	output logic o_bvalid,
	input wire logic i_bready,
	output logic [1:0] o_bresp,
	input wire logic i_arvalid,
	output logic o_arready,
	input wire logic [7:0] i_araddr,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	// Core side
	crg_reg_if.slave rif
);
	import crg_pkg::*;
	typedef struct packed {
		logic aw_h; logic [3:0] aw_i; logic w_h; logic [7:0] w_d; logic w_s;
		logic bv; logic [1:0] br; logic rv; logic [31:0] rd; logic [1:0] rr;
	} crg_axil_st_t;
	crg_axil_st_t st;
	crg_axil_st_t next_st;
	logic do_wr;
	always_comb begin
		next_st = st;
		if (i_awvalid && o_awready) begin
			next_st.aw_h = 1'b1;
			next_st.aw_i = (i_awaddr[7:6] != 2'h0) ? `CRG_IDX_NONE : i_awaddr[5:2];
		end
		if (i_wvalid && o_wready) begin
			next_st.w_h = 1'b1;
			next_st.w_d = i_wdata[7:0];
			next_st.w_s = i_wstrb[0];
		end
		do_wr = st.aw_h && st.w_h && !st.bv;
		if (do_wr) begin
			next_st.aw_h = 1'b0;
			next_st.w_h = 1'b0;
			next_st.bv = 1'b1;
			next_st.br = rif.wr_ok ? `CRG_RESP_OKAY : `CRG_RESP_SLVERR;
		end
		if (st.bv && i_bready) begin
			next_st.bv = 1'b0;
		end
		if (i_arvalid && o_arready) begin
			next_st.rv = 1'b1;
			next_st.rd = {24'h000000, rif.rd_data};
			next_st.rr = rif.rd_ok ? `CRG_RESP_OKAY : `CRG_RESP_SLVERR;
		end else if (st.rv && i_rready) begin
			next_st.rv = 1'b0;
		end
	end
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end
	assign o_awready = !st.aw_h;
	assign o_wready = !st.w_h;
	assign o_arready = !st.rv;
	assign o_bvalid = st.bv;
	assign o_bresp = st.br;
	assign o_rvalid = st.rv;
	assign o_rdata = st.rd;
	assign o_rresp = st.rr;
	assign rif.wr_en = do_wr && st.w_s;
	assign rif.wr_idx = st.aw_i;
	assign rif.wr_data = st.w_d;
	assign rif.rd_en = i_arvalid && o_arready;
	assign rif.rd_idx = (i_araddr[7:6] != 2'h0) ? `CRG_IDX_NONE : i_araddr[5:2];
endmodule // crg_axil

// ==== bench/crg_osc_model.sv ====
`timescale 1ns/1ps
// ==========
// Oscillator, lock detector and external reset circuit
module crg_osc_model (
	// Bench controls
	input wire logic i_clk_sys,
	input wire logic i_clock_lost,
	input wire logic i_quality_good,
	input wire logic i_pll_locked,
	input wire logic i_ext_reset,
	// Reset pin drive from the block
	input wire logic i_reset_pin_out,
	input wire logic i_reset_pin_oe,
	// Towards the block
	output logic o_pll_in_tol,
	output logic o_pll_track,
	output logic o_osc_loss,
	output logic o_osc_quality_ok,
	output logic o_reset_pin_n
);
	// Pulled-up pin, low when either side pulls it down
	assign o_reset_pin_n = !i_ext_reset && !(i_reset_pin_oe && !i_reset_pin_out);
	// No lock or quality while the crystal is gone
	always_ff @(posedge i_clk_sys) begin
		o_osc_loss <= i_clock_lost;
		o_osc_quality_ok <= i_quality_good && !i_clock_lost;
		o_pll_in_tol <= i_pll_locked && !i_clock_lost;
		o_pll_track <= i_pll_locked && !i_clock_lost;
	end
endmodule // crg_osc_model

// ==== bench/clock_reset_generator_pll_bench.sv ====
`timescale 1ns/1ps
`include "crg_regs.svh"
module clock_reset_generator_pll_bench;
	// ==========
	// Signals
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0] awaddr, araddr, mult, div;
	logic [31:0] wdata, rdata, d;
	logic [3:0] wstrb;
	logic wait_req, stop_req, power_on, low_volt, lost, qual, locked, ext_rst;
	logic awready, wready, bvalid, arready, rvalid;
	logic [1:0] bresp, rresp, last_resp;
	logic tol, trk, oloss, qok, pin_n, pin_out, pin_oe;
	logic pll_on, min_f, psel, div2, osc_en, sys_en, core_en, sys_rst, irq;
	int err_count, check_count, i, n;
	localparam logic [7:0] A_SYN = 8'h00, A_DIV = 8'h04, A_TFLG = 8'h08, A_FLG = 8'h0c,
		A_INT = 8'h10, A_CSEL = 8'h14, A_PCTL = 8'h18, A_PRATE = 8'h1c, A_WRATE = 8'h20,
		A_FBYP = 8'h24, A_TCTL = 8'h28, A_ARM = 8'h2c, A_MODE = 8'h30;
	logic [7:0] ma [5] = '{A_SYN, A_DIV, A_TFLG, A_FBYP, A_TCTL};
	logic [7:0] me [5] = '{8'h3f, 8'h0f, 8'h00, 8'h00, 8'h00};
	// ==========
	// Instances
	crg_top #(.WDOG_BASE(16), .RTI_BASE(8), .QC_CYCLES(8)) u_crg_top (
		.i_clk_sys(clk), .i_sys_rst(rst),
		.i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr),
		.i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb),
		.o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
		.i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
		.o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp),
		.i_pll_in_tol(tol), .i_pll_track(trk), .i_osc_loss(oloss),
		.i_osc_quality_ok(qok), .i_power_on(power_on), .i_low_volt(low_volt),
		.i_wait_req(wait_req), .i_stop_req(stop_req), .i_reset_pin_n(pin_n),
		.o_reset_pin_out(pin_out), .o_reset_pin_oe(pin_oe),
		.o_loop_multiplier_field(mult), .o_ref_divide_field(div), .o_pll_on(pll_on),
		.o_synth_min_freq(min_f), .o_pll_source_select(psel), .o_bus_div2(div2),
		.o_osc_enable(osc_en), .o_sys_clk_en(sys_en), .o_core_clk_en(core_en),
		.o_sys_reset(sys_rst), .o_lock_irq_req(irq)
	);
	crg_osc_model u_crg_osc_model (
		.i_clk_sys(clk), .i_clock_lost(lost), .i_quality_good(qual),
		.i_pll_locked(locked), .i_ext_reset(ext_rst), .i_reset_pin_out(pin_out),
		.i_reset_pin_oe(pin_oe), .o_pll_in_tol(tol), .o_pll_track(trk),
		.o_osc_loss(oloss), .o_osc_quality_ok(qok), .o_reset_pin_n(pin_n)
	);
	// ==========
	// Tasks
	task automatic stop_test();
		$display("checks=%0d mismatches=%0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [3:0] s = 4'hf);
		logic aw_hs;
		logic w_hs;
		logic b_hs;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= {24'h000000, v};
		wstrb <= s;
		bready <= 1'b1;
		b_hs = 1'b0;
		while (!b_hs) begin
			@(negedge clk);
			aw_hs = awvalid && awready;
			w_hs = wvalid && wready;
			b_hs = bready && bvalid;
			last_resp = bresp;
			@(posedge clk);
			if (aw_hs) awvalid <= 1'b0;
			if (w_hs) wvalid <= 1'b0;
			if (b_hs) bready <= 1'b0;
		end
		@(posedge clk);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		logic ar_hs;
		logic r_hs;
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		r_hs = 1'b0;
		while (!r_hs) begin
			@(negedge clk);
			ar_hs = arvalid && arready;
			r_hs = rready && rvalid;
			v = rdata;
			last_resp = rresp;
			@(posedge clk);
			if (ar_hs) arvalid <= 1'b0;
			if (r_hs) rready <= 1'b0;
		end
		@(posedge clk);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rd(a, v);
		check(v, e);
	endtask
	task automatic rst_seen(input int lim);
		for (n = 0; n < lim && sys_rst !== 1'b1; n++) @(posedge clk);
		repeat (2) @(posedge clk);
		check(32'({sys_rst, pin_oe, pin_out}), 32'h6);
		for (n = 0; n < 400 && sys_rst !== 1'b0; n++) @(posedge clk);
		check(32'(sys_rst), 32'h0);
		repeat (4) @(posedge clk);
	endtask
	// ==========
	// Clock and watchdog
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		repeat (60000) @(posedge clk);
		err_count++;
		stop_test();
	end
	// ==========
	// Tests
	initial begin
		{awvalid, wvalid, bready, arvalid, rready, wait_req, stop_req} = '0;
		{power_on, low_volt, lost, qual, locked, ext_rst} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (i = 0; i < 12; i++) rc(8'(i * 4), (i == 6) ? 32'hf1 : 32'h0);
		check(32'({pll_on, osc_en, sys_en, core_en, sys_rst}), 32'h1e);
		$display("reset values done");
		for (i = 0; i < 5; i++) begin
			wr(ma[i], 8'hff);
			rc(ma[i], 32'(me[i]));
		end
		wr(A_SYN, 8'h01, 4'h0);
		rc(A_SYN, 32'h3f);
		check(32'({mult, div}), 32'h3f0f);
		$display("field masks done");
		wr(A_CSEL, 8'h80);
		check(32'({psel, div2}), 32'h3);
		wr(A_SYN, 8'h05);
		rc(A_SYN, 32'h3f);
		wr(A_DIV, 8'h02);
		rc(A_DIV, 32'h0f);
		wr(A_CSEL, 8'h00);
		check(32'({psel, div2}), 32'h0);
		wr(A_SYN, 8'h05);
		wr(A_DIV, 8'h02);
		check(32'({mult, div}), 32'h0502);
		$display("select lockout done");
		locked <= 1'b1;
		repeat (4) @(posedge clk);
		rc(A_FLG, 32'h1c);
		wr(A_INT, 8'h10);
		check(32'(irq), 32'h1);
		wr(A_FLG, 8'h1c);
		rc(A_FLG, 32'h0c);
		check(32'(irq), 32'h0);
		wr(A_SYN, 8'h07);
		repeat (4) @(posedge clk);
		rc(A_FLG, 32'h1c);
		wr(A_FLG, 8'h10);
		locked <= 1'b0;
		repeat (4) @(posedge clk);
		rc(A_FLG, 32'h10);
		check(32'(irq), 32'h1);
		wr(A_FLG, 8'h10);
		wr(A_INT, 8'h00);
		$display("lock detector done");
		lost <= 1'b1;
		for (n = 0; n < 20 && min_f !== 1'b1; n++) @(posedge clk);
		check(32'(min_f), 32'h1);
		rc(A_FLG, 32'h03);
		lost <= 1'b0;
		repeat (30) @(posedge clk);
		check(32'(min_f), 32'h1);
		qual <= 1'b1;
		for (n = 0; n < 100 && min_f !== 1'b0; n++) @(posedge clk);
		check(32'(min_f), 32'h0);
		wr(A_FLG, 8'h02);
		rc(A_FLG, 32'h00);
		$display("self clock done");
		wr(A_PRATE, 8'h10);
		repeat (40) @(posedge clk);
		rc(A_FLG, 32'h80);
		wr(A_PRATE, 8'h00);
		wr(A_FLG, 8'h80);
		rc(A_FLG, 32'h00);
		wr(A_CSEL, 8'h20);
		wait_req <= 1'b1;
		repeat (3) @(posedge clk);
		wait_req <= 1'b0;
		check(32'(sys_en), 32'h0);
		wr(A_MODE, 8'h00);
		wr(A_CSEL, 8'h00);
		wr(A_MODE, 8'h01);
		check(32'(sys_en), 32'h1);
		wr(A_MODE, 8'h00);
		stop_req <= 1'b1;
		repeat (3) @(posedge clk);
		stop_req <= 1'b0;
		check(32'({osc_en, sys_en, core_en}), 32'h0);
		wr(A_MODE, 8'h00);
		check(32'({osc_en, sys_en}), 32'h3);
		wr(A_CSEL, 8'h40);
		wr(A_MODE, 8'h02);
		check(32'({osc_en, sys_en}), 32'h2);
		wr(A_MODE, 8'h00);
		wr(A_CSEL, 8'h00);
		$display("low power modes done");
		rd(8'h34, d);
		check(d, 32'h0);
		check(32'(last_resp), 32'(`CRG_RESP_SLVERR));
		rd(8'h40, d);
		check(32'(last_resp), 32'(`CRG_RESP_SLVERR));
		wr(8'h38, 8'h11);
		check(32'(last_resp), 32'(`CRG_RESP_SLVERR));
		$display("unmapped done");
		power_on <= 1'b1;
		repeat (2) @(posedge clk);
		power_on <= 1'b0;
		rst_seen(40);
		rc(A_FLG, 32'h40);
		wr(A_FLG, 8'h40);
		low_volt <= 1'b1;
		repeat (2) @(posedge clk);
		low_volt <= 1'b0;
		rst_seen(40);
		rc(A_FLG, 32'h20);
		wr(A_FLG, 8'h20);
		ext_rst <= 1'b1;
		repeat (3) @(posedge clk);
		ext_rst <= 1'b0;
		rst_seen(40);
		wr(A_ARM, 8'h12);
		rst_seen(40);
		wr(A_WRATE, 8'h01);
		rst_seen(20000);
		wr(A_WRATE, 8'h00);
		wr(A_PCTL, 8'hf0);
		lost <= 1'b1;
		for (n = 0; n < 40 && sys_rst !== 1'b1; n++) @(posedge clk);
		check(32'({sys_rst, min_f}), 32'h2);
		lost <= 1'b0;
		rst_seen(40);
		$display("reset sources done");
		stop_test();
	end
endmodule // clock_reset_generator_pll_bench
